// *** core/adcsq_top.sv ***
// The implementer's own choices: the placing of the registers and the AXI4-Lite register port.
`timescale 1ns/100ps
// Operation
// - Channel codes 0 to 12 route input channels 0 to 12 to the sampler.
// - Codes 13 to 15 convert a floating input without any error.
// - While enabled, start bit reads 1 during conversion, 0 when idle.
// - Enable bit 0 switches the converter on when 1, off when 0.
// - Bit 5 picks channel 2 as low reference, bit 4 channel 3 as high.
// - Pin codes up to 2 all analog; each step after turns one top digital.
// - At power-on pin config loads 0 if fuse is 1, else 7.
// - Justify bit 7 set gives right justified result, clear left justified.
// - Acquisition code gives 0,2,4,6,8,12,16,20 bit periods.
// - Clock code selects divide 2 to 64 or the internal RC clock.
// - With RC clock, wait one instruction cycle before clock runs.
// - Reset clears control and flag registers except pin config, switches off and aborts conversions.
// - At completion load result, clear start bit, set completion flag.
// - Result registers are not touched by reset.
// - Successive approximation produces a 10-bit result.
// - Programmed acquisition runs between start and conversion begin.
// - Three bit periods pass after a conversion before next acquisition.
// - Unimplemented upper control bits always read zero.
// - Small package omits channels 5 to 7; large has all 13.
// - Acquisition code 0 converts at once; sampling resumes afterwards.
// - Each conversion takes 11 bit periods.
module adcsq_top #(
   parameter bit SMALL_PACKAGE = 1'b0
) (
   // Clock and reset.
   input wire logic MCLK_I,
   input wire logic SYS_RST_I,
   // AXI4-Lite write address and data.
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [7:0] AWADDR_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   // AXI4-Lite write response.
   output logic BVALID_O,
   input wire logic BREADY_I,
   output logic [1:0] BRESP_O,
   // AXI4-Lite read.
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   input wire logic [7:0] ARADDR_I,
   output logic RVALID_O,
   input wire logic RREADY_I,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   // Analog front end.
   input wire logic PORT_ANALOG_FUSE_I,
   input wire logic INTERNAL_RC_CLOCK_I,
   input wire logic COMPARE_I,
   output logic [3:0] SAMPLE_CHANNEL_O,
   output logic SAMPLE_HOLD_O,
   output logic REF_NEG_EXT_O,
   output logic REF_POS_EXT_O,
   output logic [9:0] TRIAL_CODE_O,
   output logic [adcsq_pkg::CHANNELS-1:0] PIN_ANALOG_O,
   output logic CONV_FLAG_O
);
   import adcsq_pkg::*;

   // ------------------------------------------------------------------------
   // Decoding functions
   // ------------------------------------------------------------------------
   function automatic logic [4:0] acq_tads(input logic [2:0] code);
      case (code)
         3'h0: acq_tads = 5'h00;
         3'h1: acq_tads = 5'h02;
         3'h2: acq_tads = 5'h04;
         3'h3: acq_tads = 5'h06;
         3'h4: acq_tads = 5'h08;
         3'h5: acq_tads = 5'h0C;
         3'h6: acq_tads = 5'h10;
         default: acq_tads = 5'h14;
      endcase
   endfunction

   // Divide ratio minus one; RC codes return zero and are not used.
   function automatic logic [5:0] clk_div(input logic [2:0] code);
      case (code)
         3'h0: clk_div = 6'h01;
         3'h4: clk_div = 6'h03;
         3'h1: clk_div = 6'h07;
         3'h5: clk_div = 6'h0F;
         3'h2: clk_div = 6'h1F;
         3'h6: clk_div = 6'h3F;
         default: clk_div = 6'h00;
      endcase
   endfunction

   // ------------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------------
   logic fuse_s1, fuse_s2, rc_s1, rc_s2, rc_s3;

   // The fuse pair has no reset arm, so the strap level has settled by
   // the first edge after release, when the pin roles are loaded.
   always_ff @(posedge MCLK_I) begin
      fuse_s1 <= PORT_ANALOG_FUSE_I;
      fuse_s2 <= fuse_s1;
   end

   // The RC level passes two flops; the third only marks its edge.
   // The comparator settles from the registered trial code on this clock,
   // so it is read directly: two more flops would outlast a divide-by-two
   // bit period and break the search loop.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         {rc_s1, rc_s2, rc_s3} <= 3'h0;
      end else begin
         rc_s1 <= INTERNAL_RC_CLOCK_I;
         rc_s2 <= rc_s1;
         rc_s3 <= rc_s2;
      end
   end

   // ------------------------------------------------------------------------
   // Registers and bus slave
   // ------------------------------------------------------------------------
   logic en;
   logic [3:0] chs;
   logic vneg, vpos;
   logic [3:0] pcfg;
   logic por_done;
   logic just;
   logic [2:0] acq_code, clk_code;
   logic flag;
   logic [7:0] res_hi, res_lo;
   logic aw_full, w_full;
   logic [7:0] aw_addr, rd_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire, busy, done_evt;
   logic [31:0] rd_mux;
   logic rd_hit, wr_hit;
   adcsq_state_e state;
   logic pending;

   assign wr_fire = aw_full && w_full && !BVALID_O;
   assign wr_hit = aw_addr inside {OFS_CTRL0, OFS_CTRL1, OFS_CTRL2,
                                   OFS_RES_HI, OFS_RES_LO, OFS_FLAG};
   // Start bit shows a running or queued conversion.
   assign busy = (state inside {ST_RC_WAIT, ST_ACQUIRE, ST_CONVERT}) ||
                 pending;

   // Read multiplexer; upper bits are fixed at zero.
   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (ARADDR_I)
         OFS_CTRL0: rd_mux[5:0] = {chs, busy && en, en};
         OFS_CTRL1: rd_mux[5:0] = {vneg, vpos, pcfg};
         OFS_CTRL2: rd_mux[7:0] = {just, 1'b0, acq_code, clk_code};
         OFS_RES_HI: rd_mux[7:0] = res_hi;
         OFS_RES_LO: rd_mux[7:0] = res_lo;
         OFS_FLAG: rd_mux[FLAG_BIT] = flag;
         default: rd_hit = 1'b0;
      endcase
   end

   // Write channel: address and data are taken independently.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         aw_full <= 1'b0;
         w_full <= 1'b0;
         AWREADY_O <= 1'b1;
         WREADY_O <= 1'b1;
         BVALID_O <= 1'b0;
         BRESP_O <= RESP_OKAY;
         aw_addr <= 8'h00;
         w_data <= 32'h0000_0000;
         w_strb <= 4'h0;
      end else begin
         if (AWREADY_O && AWVALID_I) begin
            aw_full <= 1'b1;
            aw_addr <= AWADDR_I;
            AWREADY_O <= 1'b0;
         end
         if (WREADY_O && WVALID_I) begin
            w_full <= 1'b1;
            w_data <= WDATA_I;
            w_strb <= WSTRB_I;
            WREADY_O <= 1'b0;
         end
         if (wr_fire) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            BVALID_O <= 1'b1;
            BRESP_O <= wr_hit ? RESP_OKAY : RESP_SLVERR;
         end
         if (BVALID_O && BREADY_I) begin
            BVALID_O <= 1'b0;
            AWREADY_O <= 1'b1;
            WREADY_O <= 1'b1;
         end
      end
   end

   // Read channel: one read at a time, answered the cycle after address.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         ARREADY_O <= 1'b1;
         RVALID_O <= 1'b0;
         RDATA_O <= 32'h0000_0000;
         RRESP_O <= RESP_OKAY;
         rd_addr <= 8'h00;
      end else if (ARREADY_O && ARVALID_I) begin
         ARREADY_O <= 1'b0;
         RVALID_O <= 1'b1;
         RDATA_O <= rd_mux;
         RRESP_O <= rd_hit ? RESP_OKAY : RESP_SLVERR;
         rd_addr <= ARADDR_I;
      end else if (RVALID_O && RREADY_I) begin
         RVALID_O <= 1'b0;
         ARREADY_O <= 1'b1;
      end
   end

   logic wr_c0, wr_c1, wr_c2, start_req;
   assign wr_c0 = wr_fire && aw_addr == OFS_CTRL0 && w_strb[0];
   assign wr_c1 = wr_fire && aw_addr == OFS_CTRL1 && w_strb[0];
   assign wr_c2 = wr_fire && aw_addr == OFS_CTRL2 && w_strb[0];
   // A start needs the enable bit in the same written value.
   assign start_req = wr_c0 && w_data[GO_BIT] && w_data[EN_BIT];

   // Control registers; reset turns the module off.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         {chs, en} <= {CTRL0_RST[5:2], CTRL0_RST[EN_BIT]};
         {vneg, vpos} <= 2'h0;
         {just, acq_code, clk_code} <= {CTRL2_RST[7], CTRL2_RST[5:0]};
      end else begin
         if (wr_c0) begin
            en <= w_data[EN_BIT];
            chs <= w_data[CHS_LSB+:4];
         end
         if (wr_c1) begin
            vneg <= w_data[VNEG_BIT];
            vpos <= w_data[VPOS_BIT];
         end
         if (wr_c2) begin
            just <= w_data[JUST_BIT];
            acq_code <= w_data[ACQ_LSB+:3];
            clk_code <= w_data[CLK_LSB+:3];
         end
      end
   end

   // Pin roles: the fuse is caught on the first edge after reset release.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         pcfg <= PCFG_FUSE_SET;
         por_done <= 1'b0;
      end else if (!por_done) begin
         pcfg <= fuse_s2 ? PCFG_FUSE_SET : PCFG_FUSE_CLR;
         por_done <= 1'b1;
      end else if (wr_c1) begin
         pcfg <= w_data[PCFG_LSB+:4];
      end
   end

   // Completion flag: a completion in the clearing cycle wins.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         flag <= 1'b0;
      end else if (done_evt) begin
         flag <= 1'b1;
      end else if (wr_fire && aw_addr == OFS_FLAG && w_strb[0] &&
                   w_data[FLAG_BIT]) begin
         flag <= 1'b0;
      end
   end

   // ------------------------------------------------------------------------
   // Bit-period generator and sequencer
   // ------------------------------------------------------------------------
   logic rc_sel, tad_tick;
   logic [5:0] div_cnt;
   logic [2:0] tcy_cnt;
   logic [4:0] acq_cnt;
   logic [3:0] tad_cnt;
   logic [1:0] rec_cnt;
   logic [9:0] sar;
   adcsq_state_e next_launch;

   assign rc_sel = clk_code[1:0] == 2'h3;
   // RC edges are counted only after both synchroniser flops.
   assign tad_tick = (state inside {ST_ACQUIRE, ST_CONVERT, ST_RECOVER}) &&
                     (rc_sel ? (rc_s2 && !rc_s3)
                             : div_cnt == clk_div(clk_code));
   // The RC clock starts one instruction cycle late.
   assign next_launch = rc_sel ? ST_RC_WAIT
                      : acq_code == 3'h0 ? ST_CONVERT : ST_ACQUIRE;
   assign done_evt = state == ST_CONVERT && tad_tick &&
                     tad_cnt == CONV_TADS - 4'h1;

   // System clock divider, restarted whenever the sequencer is quiet.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         div_cnt <= 6'h00;
      end else if (state inside {ST_IDLE, ST_RC_WAIT} || tad_tick) begin
         div_cnt <= 6'h00;
      end else begin
         div_cnt <= div_cnt + 6'h01;
      end
   end

   // Sequencer: wait, acquire, convert, recover.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         state <= ST_IDLE;
         pending <= 1'b0;
         tcy_cnt <= 3'h0;
         acq_cnt <= 5'h00;
         tad_cnt <= 4'h0;
         rec_cnt <= 2'h0;
         sar <= 10'h000;
      end else if (wr_c0 && !w_data[EN_BIT]) begin
         state <= ST_IDLE;
         pending <= 1'b0;
      end else begin
         case (state)
            ST_IDLE: begin
               tcy_cnt <= 3'h0;
               acq_cnt <= 5'h00;
               tad_cnt <= 4'h0;
               if (start_req) begin
                  state <= next_launch;
               end
            end
            ST_RC_WAIT: begin
               tcy_cnt <= tcy_cnt + 3'h1;
               if (tcy_cnt == 3'(TCY_CYCLES - 1)) begin
                  state <= acq_code == 3'h0 ? ST_CONVERT : ST_ACQUIRE;
               end
            end
            ST_ACQUIRE: begin
               if (tad_tick) begin
                  acq_cnt <= acq_cnt + 5'h01;
                  if (acq_cnt == acq_tads(acq_code) - 5'h01) begin
                     state <= ST_CONVERT;
                  end
               end
            end
            ST_CONVERT: begin
               if (tad_tick) begin
                  tad_cnt <= tad_cnt + 4'h1;
                  // First period opens the search, then one bit each.
                  if (tad_cnt == 4'h0) begin
                     sar <= 10'h200;
                  end else begin
                     sar[4'd10 - tad_cnt] <= COMPARE_I;
                     if (tad_cnt != 4'hA) begin
                        sar[4'd9 - tad_cnt] <= 1'b1;
                     end
                  end
                  if (done_evt) begin
                     state <= ST_RECOVER;
                     rec_cnt <= 2'h0;
                  end
               end
            end
            ST_RECOVER: begin
               pending <= pending || start_req;
               if (tad_tick) begin
                  rec_cnt <= rec_cnt + 2'h1;
                  if (rec_cnt == RECOVER_TADS - 2'h1) begin
                     pending <= 1'b0;
                     tad_cnt <= 4'h0;
                     acq_cnt <= 5'h00;
                     tcy_cnt <= 3'h0;
                     state <= (pending || start_req) ? next_launch
                                                     : ST_IDLE;
                  end
               end
            end
            default: state <= ST_IDLE;
         endcase
      end
   end

   // Result pair holds its value through reset, so it has no reset arm.
   always_ff @(posedge MCLK_I) begin
      if (done_evt) begin
         if (just) begin
            res_hi <= {6'h00, sar[9:8]};
            res_lo <= {sar[7:1], COMPARE_I};
         end else begin
            res_hi <= sar[9:2];
            res_lo <= {sar[1], COMPARE_I, 6'h00};
         end
      end
   end

   // ------------------------------------------------------------------------
   // Front-end outputs
   // ------------------------------------------------------------------------
   logic [3:0] dig_cnt;
   logic [CHANNELS-1:0] next_analog;
   assign dig_cnt = pcfg > PCFG_ALL_ANALOG_MAX ? pcfg - PCFG_ALL_ANALOG_MAX
                                               : 4'h0;

   // Highest channels turn digital first; small parts lack 5 to 7.
   for (genvar i = 0; i < CHANNELS; i++) begin : g_pin
      localparam logic [3:0] IDX = 4'(i);
      assign next_analog[i] = (IDX < 4'(CHANNELS) - dig_cnt) &&
                              !(SMALL_PACKAGE && i >= 5 && i <= 7);
   end

   // Codes above the last channel still drive the mux; the front end
   // leaves those inputs open and a floating value is converted.
   always_ff @(posedge MCLK_I or posedge SYS_RST_I) begin
      if (SYS_RST_I) begin
         SAMPLE_CHANNEL_O <= 4'h0;
         SAMPLE_HOLD_O <= 1'b0;
         REF_NEG_EXT_O <= 1'b0;
         REF_POS_EXT_O <= 1'b0;
         TRIAL_CODE_O <= 10'h000;
         PIN_ANALOG_O <= '0;
         CONV_FLAG_O <= 1'b0;
      end else begin
         SAMPLE_CHANNEL_O <= chs;
         SAMPLE_HOLD_O <= state == ST_CONVERT;
         REF_NEG_EXT_O <= vneg;
         REF_POS_EXT_O <= vpos;
         TRIAL_CODE_O <= sar;
         PIN_ANALOG_O <= next_analog;
         CONV_FLAG_O <= flag;
      end
   end

   // ------------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------------
   default clocking cb @(posedge MCLK_I); endclocking
   default disable iff (SYS_RST_I);

   a_chan_route: assert property (##1 SAMPLE_CHANNEL_O == $past(chs))
      else $error("Sampled channel does not follow the select field.");
   a_start_read: assert property (RVALID_O && rd_addr == OFS_CTRL0 &&
      $rose(RVALID_O) && $past(state) == ST_CONVERT && $past(en)
      |-> RDATA_O[GO_BIT])
      else $error("Start bit read low during a conversion.");
   a_off_nolaunch: assert property (state == ST_IDLE && wr_c0 &&
      !w_data[EN_BIT] |=> state == ST_IDLE [*2])
      else $error("Conversion launched while disabled.");
   a_done_flag: assert property (done_evt |=> flag && state == ST_RECOVER
      && !busy)
      else $error("Completion did not set the flag or clear start.");
   a_conv_len: assert property (state == ST_CONVERT |-> tad_cnt <=
      CONV_TADS - 4'h1)
      else $error("Conversion ran past eleven bit periods.");
   a_recover_len: assert property ($past(state) == ST_RECOVER &&
      state != ST_RECOVER && en |-> $past(rec_cnt) ==
      RECOVER_TADS - 2'h1)
      else $error("Recovery shorter than three bit periods.");
   a_fuse_load: assert property ($rose(por_done) |-> pcfg ==
      ($past(fuse_s2) ? PCFG_FUSE_SET : PCFG_FUSE_CLR))
      else $error("Pin roles not loaded from the fuse.");
   a_acq_length: assert property ($past(state) == ST_ACQUIRE &&
      state == ST_CONVERT |-> $past(acq_cnt) == acq_tads(acq_code) - 5'h01)
      else $error("Acquisition length differs from its code.");
   a_rc_delay: assert property ($rose(state == ST_RC_WAIT) |->
      state == ST_RC_WAIT [*4])
      else $error("RC clock started before one instruction cycle.");
   a_pins_top: assert property (##1 pcfg == 4'hF |=> PIN_ANALOG_O == '0)
      else $error("Code fifteen left an analog pin.");

   c_conversion: cover property (done_evt);
   c_restart_in_recover: cover property (state == ST_RECOVER && start_req);
   c_unmapped_read: cover property (RVALID_O && RRESP_O == RESP_SLVERR);
   c_rc_conversion: cover property (state == ST_RC_WAIT ##[1:40]
      state == ST_CONVERT);

endmodule // adcsq_top

// *** pkg/adcsq_pkg.sv ***
// ---------------------------------------------------------------------------
// Shared constants of the converter sequencer
// ---------------------------------------------------------------------------
package adcsq_pkg;

   // Register byte addresses on the AXI4-Lite slave.
   localparam logic [7:0] OFS_CTRL0 = 8'h00;
   localparam logic [7:0] OFS_CTRL1 = 8'h04;
   localparam logic [7:0] OFS_CTRL2 = 8'h08;
   localparam logic [7:0] OFS_RES_HI = 8'h0C;
   localparam logic [7:0] OFS_RES_LO = 8'h10;
   localparam logic [7:0] OFS_FLAG = 8'h14;

   // Field positions of converter_control_zero.
   localparam int EN_BIT = 0;
   localparam int GO_BIT = 1;
   localparam int CHS_LSB = 2;
   // Field positions of converter_control_one.
   localparam int PCFG_LSB = 0;
   localparam int VPOS_BIT = 4;
   localparam int VNEG_BIT = 5;
   // Field positions of converter_control_two.
   localparam int CLK_LSB = 0;
   localparam int ACQ_LSB = 3;
   localparam int JUST_BIT = 7;
   // Field position of the completion flag register.
   localparam int FLAG_BIT = 0;

   // Reset values and the last all-analog pin code.
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL2_RST = 8'h00;
   localparam logic [3:0] PCFG_FUSE_SET = 4'h0;
   localparam logic [3:0] PCFG_FUSE_CLR = 4'h7;
   localparam logic [3:0] PCFG_ALL_ANALOG_MAX = 4'h2;

   // Channel count and highest implemented code.
   localparam int CHANNELS = 13;
   localparam logic [3:0] CHS_LAST = 4'hC;

   // Timing, in nanoseconds, derived clock cycles and bit periods.
   localparam int CLK_PERIOD_NS = 20;
   localparam int TCY_NS = 80;
   localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] CONV_TADS = 4'hB;
   localparam logic [1:0] RECOVER_TADS = 2'h3;

   // AXI response codes.
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Sequencer states.
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RC_WAIT,
      ST_ACQUIRE,
      ST_CONVERT,
      ST_RECOVER
   } adcsq_state_e;

endpackage

// *** verif/adcsq_analog_model.sv ***
`timescale 1ns/100ps
// ----------------------------------------------------------------------
// Sample-and-hold, comparator and RC oscillator seen by the sequencer
// ----------------------------------------------------------------------
module adcsq_analog_model (
   // Sampler side.
   input wire logic clk_i,
   input wire logic [3:0] channel_i,
   input wire logic hold_i,
   input wire logic [9:0] trial_i,
   // Comparator and oscillator.
   output logic compare_o,
   output logic rc_clock_o
);
   logic [9:0] held;
   logic junk;

   // Channels 0 to 12 carry a known level; the rest float.
   always @(posedge hold_i) begin
      held = (channel_i <= 4'hC) ? {channel_i, 6'h15} : 10'h2AA;
   end

   // Outside a hold the comparator output is meaningless, so it toggles.
   always @(posedge clk_i) begin
      junk <= ~junk;
   end
   assign compare_o = hold_i ? (held >= trial_i) : junk;

   // The RC oscillator runs free, unrelated in phase to the system clock.
   initial begin
      junk = 1'b0;
      rc_clock_o = 1'b0;
      #7;
      forever #83 rc_clock_o = ~rc_clock_o;
   end
endmodule // adcsq_analog_model

// *** verif/testbench.sv ***
`timescale 1ns/100ps
module testbench;
   import adcsq_pkg::*;
   logic clk, rst, fuse, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid, cmp, rc, hold, rneg, rpos;
   logic cflag;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, r;
   logic [3:0] chan;
   logic [9:0] trial;
   logic [12:0] pins;
   logic [31:0] d;
   int error_cnt = 0, total_checks = 0, cyc = 0;

   adcsq_top adcsq_top_i (.MCLK_I(clk), .SYS_RST_I(rst), .AWVALID_I(awvalid),
      .AWREADY_O(awready), .AWADDR_I(awaddr), .WVALID_I(wvalid),
      .WREADY_O(wready), .WDATA_I(wdata), .WSTRB_I(4'hF), .BVALID_O(bvalid),
      .BREADY_I(bready), .BRESP_O(bresp), .ARVALID_I(arvalid),
      .ARREADY_O(arready), .ARADDR_I(araddr), .RVALID_O(rvalid),
      .RREADY_I(rready), .RDATA_O(rdata), .RRESP_O(rresp),
      .PORT_ANALOG_FUSE_I(fuse), .INTERNAL_RC_CLOCK_I(rc), .COMPARE_I(cmp),
      .SAMPLE_CHANNEL_O(chan), .SAMPLE_HOLD_O(hold), .REF_NEG_EXT_O(rneg),
      .REF_POS_EXT_O(rpos), .TRIAL_CODE_O(trial), .PIN_ANALOG_O(pins),
      .CONV_FLAG_O(cflag));
   adcsq_analog_model adcsq_analog_model_i (.clk_i(clk), .channel_i(chan),
      .hold_i(hold), .trial_i(trial), .compare_o(cmp), .rc_clock_o(rc));

   // ------------------------------------------------------------------
   // Clock, timeout and shared tasks
   // ------------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Conversions at divide 64 with long acquisition dominate the run.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 90000) begin
         error_cnt++;
         end_of_test();
      end
   end
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e,
                      input string m);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %0t: %s got %h want %h", $time, m, g, e);
      end
   endtask
   // Write address and data go out together; each drops once taken.
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      awvalid <= 1'b1; wvalid <= 1'b1; awaddr <= a; wdata <= {24'h0, v};
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            r = bresp;
            bready <= 1'b0;
            break;
         end
      end
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      arvalid <= 1'b1; araddr <= a; rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            d = rdata;
            r = rresp;
            rready <= 1'b0;
            break;
         end
      end
   endtask

   // ------------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------------
   task automatic t_reset(input logic f);
      fuse <= f;
      rst <= 1'b1;
      repeat (16) @(posedge clk);
      rst <= 1'b0;
      repeat (2) @(posedge clk);
      rd(OFS_CTRL0); chk(d, 32'h0, "ctrl0 reset");
      rd(OFS_CTRL1); chk(d, f ? 32'h0 : 32'h7, "pin config reset");
      rd(OFS_CTRL2); chk(d, 32'h0, "ctrl2 reset");
      chk(pins, f ? 13'h1FFF : 13'h00FF, "pin roles after reset");
      rd(8'h18); chk(d, 32'h0, "unmapped read data");
      chk(r, RESP_SLVERR, "unmapped read response");
      wr(8'h18, 8'hFF); chk(r, RESP_SLVERR, "unmapped write");
      $display("reset test done");
   endtask
   task automatic t_pins();
      for (int c = 0; c < 16; c++) begin
         wr(OFS_CTRL1, 8'hF0 | 8'(c));
         rd(OFS_CTRL1); chk(d, 32'h30 | c, "ctrl1 readback");
         chk(pins, c < 3 ? 13'h1FFF : 13'h1FFF >> (c - 2), "pin roles");
         chk({rneg, rpos}, 2'b11, "external references");
      end
      wr(OFS_CTRL1, 8'h00);
      rd(OFS_CTRL1); chk(d, 32'h0, "ctrl1 cleared");
      chk({rneg, rpos}, 2'b00, "supply references");
      $display("pin test done");
   endtask
   task automatic t_conv(input logic [3:0] i);
      logic [7:0] c2;
      logic [9:0] v;
      c2 = {i[0], 1'b0, i[2:0], i[3:1]};
      v = {i, 6'h15};
      wr(OFS_CTRL2, c2);
      wr(OFS_CTRL0, {2'b00, i, 2'b11});
      rd(OFS_CTRL0); chk(d[1], 1'b1, "busy after start");
      for (int n = 0; n < 4000 && d[1] !== 1'b0; n++) rd(OFS_CTRL0);
      chk(d, {26'h0, i, 2'b01}, "busy clears");
      rd(OFS_FLAG); chk(d, 32'h1, "flag set");
      chk(cflag, 1'b1, "flag pin");
      if (i <= CHS_LAST) begin
         rd(OFS_RES_HI);
         chk(d, c2[7] ? {30'h0, v[9:8]} : {24'h0, v[9:2]}, "hi");
         rd(OFS_RES_LO);
         chk(d, c2[7] ? {24'h0, v[7:0]} : {24'h0, v[1:0], 6'h0}, "lo");
      end
      wr(OFS_FLAG, 8'h01);
      rd(OFS_FLAG); chk(d, 32'h0, "flag cleared");
      $display("conversion test %0d done", i);
   endtask
   task automatic t_off();
      wr(OFS_CTRL2, 8'h06);
      wr(OFS_CTRL0, 8'h07);
      repeat (100) @(posedge clk);
      wr(OFS_CTRL0, 8'h04);
      repeat (1500) @(posedge clk);
      rd(OFS_FLAG); chk(d, 32'h0, "abort raises no flag");
      wr(OFS_CTRL0, 8'h06);
      rd(OFS_CTRL0); chk(d, 32'h4, "start while off");
      repeat (1000) @(posedge clk);
      rd(OFS_FLAG); chk(d, 32'h0, "no flag while off");
      $display("off test done");
   endtask

   initial begin
      {rst, fuse, awvalid, wvalid, bready, arvalid, rready} = 7'h0;
      {awaddr, araddr, wdata} = '0;
      t_reset(1'b1);
      t_pins();
      for (int i = 0; i < 16; i++) t_conv(4'(i));
      t_off();
      wr(OFS_CTRL0, 8'h07);
      t_reset(1'b0);
      end_of_test();
   end
endmodule // testbench
